// ===== dm_sysmap.sv
`timescale 1ns/1ps
module dm_sysmap import dm_pkg::*; #(
    parameter int DEB_PERIODS = DEBOUNCE_PERIODS
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [1:0] opt_wdt_i,
    input wire logic [1:0] opt_fcpu_i,
    input wire logic opt_rst_pin_i,
    input wire logic opt_secure_i,
    input wire logic opt_debounce_i,
    input wire logic acc_rd_i,
    input wire logic acc_wr_i,
    input wire logic [7:0] acc_addr_i,
    input wire logic [7:0] acc_wdata_i,
    input wire logic pcl_carry_i,
    output logic [7:0] acc_rdata_o,
    output logic acc_rvalid_o,
    input wire logic pc_step_i,
    input wire logic pc_load_i,
    input wire logic [12:0] pc_load_val_i,
    output logic [12:0] pc_o,
    input wire logic table_read_i,
    output logic [15:0] rom_addr_o,
    input wire logic [15:0] rom_data_i,
    output logic [7:0] table_low_o,
    input wire logic timerc_reload_i,
    input wire logic sleep_i,
    input wire logic slow_mode_i,
    input wire logic slow_osc_i,
    input wire logic slow_rc_i,
    input wire logic rst_pin_i,
    output logic icycle_o,
    output logic wdt_run_o,
    output logic wdt_clear_o,
    output logic ext_reset_o,
    output logic port3_bit7_io_o,
    output logic port3_bit7_pullup_o,
    output logic rom_protect_o
);
    localparam int DCW = $clog2(DEB_PERIODS + 1);

    logic cap_done_q;
    dm_wdt_t wdt_mode_q;
    logic [2:0] fcpu_div_q;
    logic rst_pin_mode_q;
    logic secure_q;
    logic debounce_q;
    logic [7:0] ram_q [RAM_SIZE];
    logic [7:0] sys_q [128];
    logic [7:0] fifo_q [FIFO_DEPTH];
    logic [12:0] pc_q;
    logic [8:0] dir_addr;
    logic [8:0] fin_addr;
    logic is_ram;
    logic is_sys;
    logic [7:0] ram_idx;
    logic [6:0] sys_idx;
    logic [7:0] fifo_ptr;
    logic fifo_ok;
    logic [7:0] fifo_rd;
    logic [7:0] rd_val;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic wclr_q;
    logic [7:0] tlow_q;
    logic [2:0] osc_sync_q;
    logic [2:0] rc_sync_q;
    logic [1:0] pin_sync_q;
    logic [2:0] div_cnt_q;
    logic [1:0] slow_cnt_q;
    logic icyc_q;
    logic [DCW-1:0] deb_cnt_q;
    logic ext_rst_q;
    logic osc_rise;
    logic rc_rise;
    logic pin_low;

    // Option straps are caught once, on the first edge after reset release.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            cap_done_q <= 1'b0;
            wdt_mode_q <= DM_WDT_OFF;
            fcpu_div_q <= DIV_BY1;
            rst_pin_mode_q <= 1'b0;
            secure_q <= 1'b0;
            debounce_q <= 1'b0;
        end else if (!cap_done_q) begin
            cap_done_q <= 1'b1;
            case (opt_wdt_i)
                WDT_CODE_ALWAYS: wdt_mode_q <= DM_WDT_ALWAYS;
                WDT_CODE_ENABLE: wdt_mode_q <= DM_WDT_ENABLE;
                default: wdt_mode_q <= DM_WDT_OFF;
            endcase
            case (opt_fcpu_i)
                DIV_CODE_BY1: fcpu_div_q <= DIV_BY1;
                DIV_CODE_BY2: fcpu_div_q <= DIV_BY2;
                default: fcpu_div_q <= DIV_BY4;
            endcase
            rst_pin_mode_q <= opt_rst_pin_i;
            secure_q <= opt_secure_i;
            debounce_q <= opt_debounce_i;
        end
    end

    // Direct addresses below 80h follow the bank select; 80h-FFh reach system registers, except E6h and E7h, which go through the index pairs.
    assign dir_addr = (acc_addr_i[7] == 1'b0) ?
        {sys_q[OFF_RAM_BANK_SELECT[6:0]][BANK_BIT], acc_addr_i} : {1'b0, acc_addr_i};

    always_comb begin
        fin_addr = dir_addr;
        if (dir_addr == {1'b0, OFF_PAIR_ONE_PORT}) begin
            fin_addr = {sys_q[OFF_INDEX_HIGH[6:0]][0], sys_q[OFF_INDEX_LOW[6:0]]};
        end else if (dir_addr == {1'b0, OFF_PAIR_TWO_PORT}) begin
            fin_addr = {sys_q[OFF_ROM_INDEX_MID[6:0]][0], sys_q[OFF_ROM_INDEX_LOW[6:0]]};
        end
    end

    always_comb begin
        is_ram = 1'b0;
        is_sys = 1'b0;
        ram_idx = fin_addr[7:0];
        sys_idx = fin_addr[6:0];
        if (fin_addr < SYSREG_BASE) begin
            is_ram = 1'b1;
        end else if (fin_addr < BANK1_BASE) begin
            // An indirect pointer that lands on an indirect port reaches nothing.
            is_sys = SYSREG_IMPL[fin_addr[6:0]] && (dir_addr == fin_addr || (fin_addr[7:0] != OFF_PAIR_ONE_PORT
                && fin_addr[7:0] != OFF_PAIR_TWO_PORT));
        end else if (fin_addr <= BANK1_LAST) begin
            is_ram = 1'b1;
            ram_idx = 8'(fin_addr - BANK1_BASE + 9'(RAM_BANK0_SIZE));
        end
    end

    assign fifo_ptr = sys_q[OFF_FIFO_PTR_LOW[6:0]];
    assign fifo_ok = (fifo_ptr < 8'(FIFO_DEPTH)) && (fifo_ptr[4:3] != FIFO_HOLE);
    assign fifo_rd = fifo_ok ? fifo_q[fifo_ptr[4:0]] : RESET_BYTE;

    always_comb begin
        rd_val = RESET_BYTE;
        if (is_ram) begin
            rd_val = ram_q[ram_idx];
        end else if (is_sys) begin
            case (fin_addr[7:0])
                OFF_PROG_COUNTER_LOW: rd_val = pc_q[7:0];
                OFF_PROG_COUNTER_HIGH: rd_val = {3'h0, pc_q[12:8]};
                OFF_FIFO_READ_PORT: rd_val = fifo_rd;
                OFF_WATCHDOG_CLEAR: rd_val = RESET_BYTE;
                OFF_PAIR_ONE_PORT: rd_val = RESET_BYTE;
                OFF_PAIR_TWO_PORT: rd_val = RESET_BYTE;
                default: rd_val = sys_q[sys_idx];
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            rdata_q <= RESET_BYTE;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= acc_rd_i;
            if (acc_rd_i) begin
                rdata_q <= rd_val;
            end
        end
    end

    // General purpose RAM of both banks.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < RAM_SIZE; i++) begin
                ram_q[i] <= RESET_BYTE;
            end
        end else if (acc_wr_i && is_ram) begin
            ram_q[ram_idx] <= acc_wdata_i;
        end
    end

    // Plain system registers, including index pairs, flags, stack slots and stack pointer.
    generate
        for (genvar g = 0; g < 128; g++) begin : g_sys
            always_ff @(posedge mclk_i) begin
                if (!rstn_i || !SYSREG_IMPL[g]) begin
                    sys_q[g] <= RESET_BYTE;
                end else if (g == int'(OFF_LOOKUP_HIGH[6:0]) && table_read_i) begin
                    sys_q[g] <= rom_data_i[15:8];
                end else if (g == int'(OFF_TIMERC_COUNT[6:0]) && timerc_reload_i) begin
                    sys_q[g] <= sys_q[OFF_TIMERC_RELOAD[6:0]];
                end else if (acc_wr_i && is_sys && sys_idx == 7'(g)) begin
                    sys_q[g] <= acc_wdata_i;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                fifo_q[i] <= RESET_BYTE;
            end
        end else if (acc_wr_i && is_sys && fin_addr[7:0] == OFF_FIFO_WRITE_PORT && fifo_ok) begin
            fifo_q[fifo_ptr[4:0]] <= acc_wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            pc_q <= '0;
        end else if (acc_wr_i && is_sys && fin_addr[7:0] == OFF_PROG_COUNTER_LOW) begin
            pc_q[7:0] <= acc_wdata_i;
            if (pcl_carry_i) begin
                pc_q[12:8] <= pc_q[12:8] + 5'h01;
            end
        end else if (acc_wr_i && is_sys && fin_addr[7:0] == OFF_PROG_COUNTER_HIGH) begin
            pc_q[12:8] <= acc_wdata_i[4:0];
        end else if (pc_load_i) begin
            pc_q <= pc_load_val_i;
        end else if (pc_step_i) begin
            pc_q <= pc_q + 13'h0001;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            wclr_q <= 1'b0;
            tlow_q <= RESET_BYTE;
        end else begin
            wclr_q <= acc_wr_i && is_sys && fin_addr[7:0] == OFF_WATCHDOG_CLEAR;
            if (table_read_i) begin
                tlow_q <= rom_data_i[7:0];
            end
        end
    end

    // The pin input passes two flip-flops and the slow clock inputs three; edges are taken from the later stages.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            osc_sync_q <= '0;
            rc_sync_q <= '0;
            pin_sync_q <= 2'h3;
        end else begin
            osc_sync_q <= {osc_sync_q[1:0], slow_osc_i};
            rc_sync_q <= {rc_sync_q[1:0], slow_rc_i};
            pin_sync_q <= {pin_sync_q[0], rst_pin_i};
        end
    end

    assign osc_rise = osc_sync_q[1] && !osc_sync_q[2];
    assign rc_rise = rc_sync_q[1] && !rc_sync_q[2];
    assign pin_low = !pin_sync_q[1];

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            div_cnt_q <= '0;
            slow_cnt_q <= '0;
            icyc_q <= 1'b0;
        end else if (slow_mode_i) begin
            div_cnt_q <= '0;
            icyc_q <= 1'b0;
            if (osc_rise) begin
                slow_cnt_q <= slow_cnt_q + 2'h1;
                icyc_q <= slow_cnt_q == 2'(SLOW_DIVIDE - 1);
            end
        end else begin
            slow_cnt_q <= '0;
            icyc_q <= div_cnt_q == fcpu_div_q - 3'h1;
            div_cnt_q <= (div_cnt_q == fcpu_div_q - 3'h1) ? 3'h0 : div_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            deb_cnt_q <= '0;
            ext_rst_q <= 1'b0;
        end else if (!rst_pin_mode_q || !pin_low) begin
            deb_cnt_q <= '0;
            ext_rst_q <= 1'b0;
        end else if (!debounce_q) begin
            ext_rst_q <= 1'b1;
        end else if (deb_cnt_q == DCW'(DEB_PERIODS)) begin
            ext_rst_q <= 1'b1;
        end else if (rc_rise) begin
            deb_cnt_q <= deb_cnt_q + DCW'(1);
        end
    end

    assign acc_rdata_o = rdata_q;
    assign acc_rvalid_o = rvalid_q;
    assign pc_o = pc_q;
    assign rom_addr_o = {sys_q[OFF_ROM_INDEX_MID[6:0]], sys_q[OFF_ROM_INDEX_LOW[6:0]]};
    assign table_low_o = tlow_q;
    assign icycle_o = icyc_q;
    assign wdt_run_o = wdt_mode_q == DM_WDT_ALWAYS || (wdt_mode_q == DM_WDT_ENABLE && !sleep_i);
    assign wdt_clear_o = wclr_q;
    assign ext_reset_o = ext_rst_q;
    assign port3_bit7_io_o = !rst_pin_mode_q && pin_sync_q[1];
    assign port3_bit7_pullup_o = !rst_pin_mode_q && sys_q[OFF_PORT3_PULLUP[6:0]][PORT3_BIT7];
    assign rom_protect_o = secure_q;

    a_pcl_carry: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        acc_wr_i && is_sys && fin_addr[7:0] == OFF_PROG_COUNTER_LOW && !pc_load_i
        |=> pc_q[12:8] == $past(pc_q[12:8]) + 5'($past(pcl_carry_i)))
        else $error("program counter high byte wrong after low byte write");
    a_wdt_clear: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        acc_wr_i && acc_addr_i == OFF_WATCHDOG_CLEAR |=> wdt_clear_o ##1 !wdt_clear_o || acc_wr_i)
        else $error("watchdog clear pulse missing");
    a_table_high: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        table_read_i |=> sys_q[OFF_LOOKUP_HIGH[6:0]] == $past(rom_data_i[15:8]) && table_low_o == $past(rom_data_i[7:0]))
        else $error("table read bytes not stored");
    a_unmapped_zero: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        acc_rd_i && acc_addr_i[7] && !SYSREG_IMPL[acc_addr_i[6:0]] |=> acc_rvalid_o && acc_rdata_o == RESET_BYTE)
        else $error("unassigned register did not read zero");
    a_reload_value: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        timerc_reload_i |=> sys_q[OFF_TIMERC_COUNT[6:0]] == $past(sys_q[OFF_TIMERC_RELOAD[6:0]]))
        else $error("counter not reloaded");
    a_wdt_sleep: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        cap_done_q && sleep_i && wdt_mode_q != DM_WDT_ALWAYS |-> !wdt_run_o)
        else $error("watchdog runs in sleep");
    a_fifo_rw: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        acc_wr_i && acc_addr_i == OFF_FIFO_WRITE_PORT && fifo_ok ##1 acc_rd_i && acc_addr_i == OFF_FIFO_READ_PORT
        && $stable(fifo_ptr) |=> acc_rdata_o == $past(acc_wdata_i, 2))
        else $error("buffer byte not read back");
    a_slow_divide: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        slow_mode_i && $past(slow_mode_i) && icycle_o |-> $past(slow_cnt_q) == 2'(SLOW_DIVIDE - 1))
        else $error("slow instruction clock not divided by four");
    a_bank_ram: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        acc_wr_i && !acc_addr_i[7] && dir_addr > BANK1_LAST |-> !is_ram)
        else $error("write beyond bank 1 reached RAM");

    a_read_valid: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $past(rstn_i) |-> acc_rvalid_o == $past(acc_rd_i))
        else $error("read valid not one cycle after strobe");
    a_direct_ram: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        acc_rd_i && !acc_addr_i[7] && !sys_q[OFF_RAM_BANK_SELECT[6:0]][BANK_BIT]
        |=> acc_rdata_o == $past(ram_q[acc_addr_i[6:0]]))
        else $error("bank 0 RAM read wrong");
    a_fifo_hole: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        acc_rd_i && acc_addr_i == OFF_FIFO_READ_PORT && !fifo_ok |=> acc_rdata_o == RESET_BYTE)
        else $error("buffer hole did not read zero");
    a_pc_high_read: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        acc_rd_i && acc_addr_i == OFF_PROG_COUNTER_HIGH |=> acc_rdata_o == {3'h0, $past(pc_q[12:8])})
        else $error("program counter high byte read wrong");
    a_pc_step: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        pc_step_i && !pc_load_i && !acc_wr_i |=> pc_q == $past(pc_q) + 13'h0001)
        else $error("program counter did not step");
    a_pc_load: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        pc_load_i && !acc_wr_i |=> pc_q == $past(pc_load_val_i))
        else $error("program counter did not load");
    a_reset_mode: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ext_reset_o |-> rst_pin_mode_q)
        else $error("external reset raised in I/O mode");
    a_no_debounce: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        rst_pin_mode_q && !debounce_q && pin_low |=> ext_reset_o)
        else $error("undebounced reset late");
    a_fast_tick: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $past(rstn_i) && !$past(slow_mode_i) && $past(fcpu_div_q) == DIV_BY1 |-> icycle_o)
        else $error("undivided instruction tick missing");
    a_wdt_off: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        wdt_mode_q == DM_WDT_OFF |-> !wdt_run_o)
        else $error("disabled watchdog runs");
    a_wdt_always: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        wdt_mode_q == DM_WDT_ALWAYS |-> wdt_run_o)
        else $error("always on watchdog stopped");
    a_wdt_awake: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        wdt_mode_q == DM_WDT_ENABLE && !sleep_i |-> wdt_run_o)
        else $error("enabled watchdog stopped while awake");
    a_slow_quiet: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        slow_mode_i && $past(slow_mode_i) && !$past(osc_rise) |-> !icycle_o)
        else $error("slow tick without slow clock edge");
    a_bank1_gap: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        acc_rd_i && !acc_addr_i[7] && sys_q[OFF_RAM_BANK_SELECT[6:0]][BANK_BIT]
        && {1'b1, acc_addr_i} > BANK1_LAST |=> acc_rdata_o == RESET_BYTE)
        else $error("bank 1 gap did not read zero");

    c_indirect_one: cover property (@(posedge mclk_i) disable iff (!rstn_i) acc_rd_i && acc_addr_i == OFF_PAIR_ONE_PORT);
    c_pcl_carry: cover property (@(posedge mclk_i) disable iff (!rstn_i) acc_wr_i && pcl_carry_i);
    c_debounced: cover property (@(posedge mclk_i) disable iff (!rstn_i) debounce_q && $rose(ext_reset_o));
    c_bank1_ram: cover property (@(posedge mclk_i) disable iff (!rstn_i) acc_wr_i && is_ram && fin_addr[8]);
    c_slow_tick: cover property (@(posedge mclk_i) disable iff (!rstn_i) slow_mode_i && icycle_o);
endmodule : dm_sysmap

// ===== dm_pkg.sv
package dm_pkg;
    localparam logic [7:0] OFF_INDEX_LOW = 8'h80;
    localparam logic [7:0] OFF_INDEX_HIGH = 8'h81;
    localparam logic [7:0] OFF_LOOKUP_HIGH = 8'h82;
    localparam logic [7:0] OFF_ROM_INDEX_LOW = 8'h83;
    localparam logic [7:0] OFF_ROM_INDEX_MID = 8'h84;
    localparam logic [7:0] OFF_STATUS_FLAGS = 8'h86;
    localparam logic [7:0] OFF_RAM_BANK_SELECT = 8'h87;
    localparam logic [7:0] OFF_TIMERC_COUNT = 8'h89;
    localparam logic [7:0] OFF_TIMERC_RELOAD = 8'h8A;
    localparam logic [7:0] OFF_FIFO_PTR_LOW = 8'hA3;
    localparam logic [7:0] OFF_FIFO_READ_PORT = 8'hA5;
    localparam logic [7:0] OFF_FIFO_WRITE_PORT = 8'hA6;
    localparam logic [7:0] OFF_WATCHDOG_CLEAR = 8'hCC;
    localparam logic [7:0] OFF_PROG_COUNTER_LOW = 8'hCE;
    localparam logic [7:0] OFF_PROG_COUNTER_HIGH = 8'hCF;
    localparam logic [7:0] OFF_STACK_POINTER = 8'hDF;
    localparam logic [7:0] OFF_PORT3_PULLUP = 8'hE3;
    localparam logic [7:0] OFF_PAIR_ONE_PORT = 8'hE6;
    localparam logic [7:0] OFF_PAIR_TWO_PORT = 8'hE7;
    // One bit per system register offset 80h..FFh, bit 0 is 80h.
    localparam logic [127:0] SYSREG_IMPL = 128'hFFFF_00EF_832F_D72E_8103_9878_01DF_07DF;
    localparam logic [8:0] SYSREG_BASE = 9'h080;
    localparam logic [8:0] BANK1_BASE = 9'h100;
    localparam logic [8:0] BANK1_LAST = 9'h120;
    localparam int RAM_BANK0_SIZE = 128;
    localparam int RAM_BANK1_SIZE = 33;
    localparam int RAM_SIZE = RAM_BANK0_SIZE + RAM_BANK1_SIZE;
    localparam int BANK_BIT = 0;
    localparam int PORT3_BIT7 = 7;
    localparam int PC_WIDTH = 13;
    localparam int FIFO_DEPTH = 32;
    localparam logic [1:0] FIFO_HOLE = 2'h1;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int DEBOUNCE_PERIODS = 128;
    localparam int SLOW_DIVIDE = 4;
    localparam logic [1:0] WDT_CODE_ALWAYS = 2'h0;
    localparam logic [1:0] WDT_CODE_ENABLE = 2'h1;
    localparam logic [1:0] DIV_CODE_BY1 = 2'h0;
    localparam logic [1:0] DIV_CODE_BY2 = 2'h1;
    localparam logic [2:0] DIV_BY1 = 3'h1;
    localparam logic [2:0] DIV_BY2 = 3'h2;
    localparam logic [2:0] DIV_BY4 = 3'h4;
    typedef enum logic [1:0] {DM_WDT_ALWAYS, DM_WDT_ENABLE, DM_WDT_OFF} dm_wdt_t;
endpackage : dm_pkg

// ===== data_memory_and_sysreg_map_test.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("unexpected %s expected %h seen %h", what, exp, got); end end
module data_memory_and_sysreg_map_test;
    import dm_pkg::*;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [1:0] opt_wdt_i = 2'h0;
    logic [1:0] opt_fcpu_i = 2'h0;
    logic opt_rst_pin_i = 1'b1;
    logic opt_secure_i = 1'b0;
    logic opt_debounce_i = 1'b0;
    logic acc_rd_i = 1'b0;
    logic acc_wr_i = 1'b0;
    logic [7:0] acc_addr_i = 8'h00;
    logic [7:0] acc_wdata_i = 8'h00;
    logic pcl_carry_i = 1'b0;
    logic pc_step_i = 1'b0;
    logic pc_load_i = 1'b0;
    logic [12:0] pc_load_val_i = 13'h0000;
    logic table_read_i = 1'b0;
    logic [15:0] rom_data_i = 16'h0000;
    logic timerc_reload_i = 1'b0;
    logic sleep_i = 1'b0;
    logic slow_mode_i = 1'b0;
    logic slow_osc_i = 1'b0;
    logic slow_rc_i = 1'b0;
    logic rst_pin_i = 1'b1;
    logic [7:0] acc_rdata_o;
    logic acc_rvalid_o;
    logic [12:0] pc_o;
    logic [15:0] rom_addr_o;
    logic [7:0] table_low_o;
    logic icycle_o, wdt_run_o, wdt_clear_o, ext_reset_o, port3_bit7_io_o, port3_bit7_pullup_o, rom_protect_o;
    int error_cnt = 0;
    int checks = 0;
    int tick_cnt = 0;

    dm_sysmap #(.DEB_PERIODS(4)) u_dm_sysmap (.mclk_i(mclk_i), .rstn_i(rstn_i), .opt_wdt_i(opt_wdt_i),
        .opt_fcpu_i(opt_fcpu_i), .opt_rst_pin_i(opt_rst_pin_i), .opt_secure_i(opt_secure_i),
        .opt_debounce_i(opt_debounce_i), .acc_rd_i(acc_rd_i), .acc_wr_i(acc_wr_i), .acc_addr_i(acc_addr_i),
        .acc_wdata_i(acc_wdata_i), .pcl_carry_i(pcl_carry_i), .acc_rdata_o(acc_rdata_o),
        .acc_rvalid_o(acc_rvalid_o), .pc_step_i(pc_step_i), .pc_load_i(pc_load_i), .pc_load_val_i(pc_load_val_i),
        .pc_o(pc_o), .table_read_i(table_read_i), .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i),
        .table_low_o(table_low_o), .timerc_reload_i(timerc_reload_i), .sleep_i(sleep_i),
        .slow_mode_i(slow_mode_i), .slow_osc_i(slow_osc_i), .slow_rc_i(slow_rc_i), .rst_pin_i(rst_pin_i),
        .icycle_o(icycle_o), .wdt_run_o(wdt_run_o), .wdt_clear_o(wdt_clear_o), .ext_reset_o(ext_reset_o),
        .port3_bit7_io_o(port3_bit7_io_o), .port3_bit7_pullup_o(port3_bit7_pullup_o),
        .rom_protect_o(rom_protect_o));

    initial begin
        forever #20 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i) begin
        if (icycle_o === 1'b1) tick_cnt++;
    end

    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step(1);
        acc_wr_i = 1'b1;
        acc_addr_i = a;
        acc_wdata_i = d;
        step(1);
        acc_wr_i = 1'b0;
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
        int k;
        step(1);
        acc_rd_i = 1'b1;
        acc_addr_i = a;
        step(1);
        acc_rd_i = 1'b0;
        k = 0;
        while (acc_rvalid_o !== 1'b1 && k < 3) begin
            step(1);
            k++;
        end
        `CHK("read valid", 1'b1, acc_rvalid_o)
        `CHK(n, e, acc_rdata_o)
    endtask : rc

    task automatic do_reset(input int k);
        rstn_i = 1'b0;
        opt_wdt_i = 2'(k);
        opt_fcpu_i = 2'(k);
        opt_secure_i = (k == 1);
        opt_rst_pin_i = (k != 1);
        opt_debounce_i = (k == 2);
        step(5);
        rstn_i = 1'b1;
        step(2);
    endtask : do_reset

    task automatic test_ram();
        rc(8'h85, 8'h00, "unassigned reset");
        wr(8'h85, 8'h5A);
        rc(8'h85, 8'h00, "unassigned write");
        wr(8'h10, 8'h3C);
        wr(8'h81, 8'h00);
        wr(8'h80, 8'h10);
        rc(8'hE6, 8'h3C, "pair one read");
        wr(8'hE6, 8'h4B);
        rc(8'h10, 8'h4B, "pair one write");
        wr(8'h84, 8'h01);
        wr(8'h83, 8'h05);
        wr(8'hE7, 8'h9D);
        wr(8'h87, 8'h01);
        rc(8'h05, 8'h9D, "bank1 via pair two");
        wr(8'h20, 8'h66);
        rc(8'h20, 8'h66, "bank1 top");
        wr(8'h21, 8'h77);
        rc(8'h21, 8'h00, "bank1 beyond top");
        rc(8'h86, 8'h00, "flags reset");
        wr(8'h86, 8'hC7);
        rc(8'h86, 8'hC7, "status flags");
        wr(8'h87, 8'h00);
        rc(8'h05, 8'h00, "bank0 untouched");
        rc(8'h10, 8'h4B, "bank0 kept");
        $display("test ram done");
    endtask : test_ram

    task automatic test_fifo();
        logic [7:0] ptr [9] = '{8'h00, 8'h07, 8'h10, 8'h17, 8'h18, 8'h1F, 8'h08, 8'h0F, 8'h20};
        foreach (ptr[i]) begin
            wr(8'hA3, ptr[i]);
            wr(8'hA6, ptr[i] ^ 8'hA5);
        end
        foreach (ptr[i]) begin
            wr(8'hA3, ptr[i]);
            rc(8'hA5, (i < 6) ? (ptr[i] ^ 8'hA5) : 8'h00, "fifo byte");
        end
        wr(8'hA3, 8'h1F);
        step(1);
        acc_wr_i = 1'b1;
        acc_addr_i = 8'hA6;
        acc_wdata_i = 8'h3E;
        step(1);
        acc_wr_i = 1'b0;
        acc_rd_i = 1'b1;
        acc_addr_i = 8'hA5;
        step(1);
        acc_rd_i = 1'b0;
        `CHK("fifo back to back", 8'h3E, acc_rdata_o)
        $display("test fifo done");
    endtask : test_fifo

    task automatic test_core();
        wr(8'hDF, 8'h07);
        wr(8'hF0, 8'h12);
        wr(8'hFF, 8'h1F);
        rc(8'hDF, 8'h07, "stack pointer");
        rc(8'hF0, 8'h12, "stack first");
        rc(8'hFF, 8'h1F, "stack last");
        wr(8'hCC, 8'h5A);
        `CHK("wdt clear pulse", 1'b1, wdt_clear_o)
        step(1);
        `CHK("wdt clear end", 1'b0, wdt_clear_o)
        wr(8'h8A, 8'h77);
        wr(8'h89, 8'h11);
        timerc_reload_i = 1'b1;
        step(1);
        timerc_reload_i = 1'b0;
        rc(8'h89, 8'h77, "reload count");
        pc_load_i = 1'b1;
        pc_load_val_i = 13'h1ABC;
        step(1);
        pc_load_i = 1'b0;
        pc_step_i = 1'b1;
        step(1);
        pc_step_i = 1'b0;
        `CHK("pc step", 13'h1ABD, pc_o)
        rc(8'hCE, 8'hBD, "pc low");
        rc(8'hCF, 8'h1A, "pc high");
        wr(8'hCE, 8'hF0);
        `CHK("pc no carry", 13'h1AF0, pc_o)
        pcl_carry_i = 1'b1;
        wr(8'hCE, 8'h05);
        pcl_carry_i = 1'b0;
        `CHK("pc carry", 13'h1B05, pc_o)
        wr(8'hCF, 8'hFF);
        rc(8'hCF, 8'h1F, "pc high width");
        wr(8'h84, 8'h12);
        wr(8'h83, 8'h34);
        `CHK("rom address", 16'h1234, rom_addr_o)
        rom_data_i = 16'hABCD;
        table_read_i = 1'b1;
        step(1);
        table_read_i = 1'b0;
        `CHK("table low", 8'hCD, table_low_o)
        rc(8'h82, 8'hAB, "table high");
        $display("test core done");
    endtask : test_core

    task automatic test_options(input int k);
        do_reset(k);
        `CHK("protect", (k == 1), rom_protect_o)
        sleep_i = 1'b0;
        #1;
        `CHK("wdt awake", (k != 2), wdt_run_o)
        sleep_i = 1'b1;
        #1;
        `CHK("wdt asleep", (k == 0), wdt_run_o)
        sleep_i = 1'b0;
        tick_cnt = 0;
        step(16);
        `CHK("fast ticks", 16 / (1 << k), tick_cnt)
        slow_mode_i = 1'b1;
        step(1);
        tick_cnt = 0;
        repeat (16) begin
            slow_osc_i = 1'b1;
            step(2);
            slow_osc_i = 1'b0;
            step(2);
        end
        step(6);
        `CHK("slow ticks", 16 / SLOW_DIVIDE, tick_cnt)
        slow_mode_i = 1'b0;
        wr(8'hE3, 8'h80);
        `CHK("pin pullup", (k == 1), port3_bit7_pullup_o)
        rst_pin_i = 1'b0;
        step(10);
        `CHK("reset asserted", (k == 0), ext_reset_o)
        `CHK("io low", 1'b0, port3_bit7_io_o)
        if (k == 2) begin
            repeat (6) begin
                slow_rc_i = 1'b1;
                step(2);
                slow_rc_i = 1'b0;
                step(2);
            end
            step(4);
            `CHK("debounced reset", 1'b1, ext_reset_o)
        end
        rst_pin_i = 1'b1;
        step(6);
        `CHK("reset released", 1'b0, ext_reset_o)
        `CHK("io high", (k == 1), port3_bit7_io_o)
        $display("test options %0d done", k);
    endtask : test_options

    task automatic wrap_up();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    initial begin
        do_reset(0);
        test_ram();
        test_fifo();
        test_core();
        for (int k = 0; k < 3; k++) begin
            test_options(k);
        end
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge mclk_i);
        error_cnt++;
        wrap_up();
    end
endmodule : data_memory_and_sysreg_map_test
